// [hdl/tks_map.vh]
// register map, field layout, codes and timing for the touch key parameter block
//
// Behaviour
// R1 - touch byte: keys 1..4 in bits 0..3, touched reads 1, bits 7..4 zero
// R2 - enable request bit 7: 0 enables the selected key, 1 disables it
// R3 - enable request bits 3..0: 0 selects all keys, 1..4 select one key
// R4 - sleep config bit 6 clear: low power stays active whatever the keys do
// R5 - bit 6 set: low power paused while any key detects, resumed afterwards
// R6 - duration factor 0x00 or 0x20..0x3E disables low power
// R7 - factor 0x01..0x19 sleeps factor times 20 ms per interval
// R8 - factor 0x3F enters deep sleep immediately
// R9 - deep sleep left only by reset or a frame carrying our address
// R10 - any bus activity wakes the device from sleep
// R11 - our address seen in low power is not acknowledged but wakes us
// R12 - host repeats a command whose address went unacknowledged while waking
// R13 - output level bytes: byte one outputs 1..8, byte two outputs 9..13
// R14 - group policy bit 0: first touched key locks out the group's others
// R15 - group policy bit 1: only the strongest touched key of the group reports
// R16 - membership byte bit x-1 places the key in group x, several allowed
// R17 - debug codes 0x01 cal, 0x02 released, 0x04 touched, 0x08 error, 0x11 recal
// R18 - debug codes 0x14 detect filter, 0x24 release filter
// R19 - any key enable change recalibrates every key still enabled
// R20 - opcode 0x92 then config byte selects sleep; answered with a result code
// R21 - opcode 0x97 then request byte changes one key enable; result code follows
// R22 - bytes 0x00 0x09 then policy and memberships define groups; result code
// R23 - reserved bits read zero and are ignored on writes
// R24 - sleep intervals timed by a 20 ms tick from the own clock
`ifndef TKS_MAP_VH
`define TKS_MAP_VH

// register offsets
`define TKS_REG_OPCODE 4'h0
`define TKS_REG_SLEEP 4'h1
`define TKS_REG_KEYEN 4'h2
`define TKS_REG_POLICY 4'h3
`define TKS_REG_MEMB0 4'h4
`define TKS_REG_MEMB3 4'h7
`define TKS_REG_OUT1 4'h8
`define TKS_REG_OUT2 4'h9
`define TKS_REG_TOUCH 4'hA
`define TKS_REG_RESULT 4'hB
`define TKS_REG_DBG0 4'hC
`define TKS_REG_DBG3 4'hF

// opcodes
`define TKS_OP_SLEEP 8'h92
`define TKS_OP_KEYEN 8'h97
`define TKS_OP_GROUP 16'h0009

// result codes
`define TKS_RES_OK 8'h01
`define TKS_RES_BADCMD 8'h83
`define TKS_RES_BADPAR 8'h85

// field positions
`define TKS_EN_STATE_BIT 7
`define TKS_FREERUN_BIT 6
`define TKS_KEYID_ALL 4'h0
`define TKS_KEYID_MAX 4'h4
`define TKS_OUT2_MASK 8'h1F

// sleep duration factor values
`define TKS_FAC_OFF 6'h00
`define TKS_FAC_MAX_LP 6'h19
`define TKS_FAC_DEEP 6'h3F

// debug codes
`define TKS_DBG_CAL 8'h01
`define TKS_DBG_REL 8'h02
`define TKS_DBG_TOUCH 8'h04
`define TKS_DBG_ERR 8'h08
`define TKS_DBG_RECAL 8'h11
`define TKS_DBG_DI 8'h14
`define TKS_DBG_EDI 8'h24

// timing
`define TKS_CLK_HZ 200000000
`define TKS_TICK_MS 20
`define TKS_TICK_CYC ((`TKS_CLK_HZ / 1000) * `TKS_TICK_MS)

`endif

// [hdl/tks_group.v]
// one suppression group: decides which member keys may report
`include "tks_map.vh"
module tks_group #(
    parameter KEYS = 4,
    parameter LW = 8
) (
    input wire i_clk,
    input wire i_rstn,
    input wire [KEYS-1:0] i_member,
    input wire i_policy,
    input wire [KEYS-1:0] i_touch,
    input wire [KEYS*LW-1:0] i_level,
    output reg [KEYS-1:0] o_allow
);
    reg [KEYS-1:0] owner;
    reg [KEYS-1:0] next_owner;
    reg [KEYS-1:0] best;
    reg [LW-1:0] best_lvl;
    reg found;
    wire [KEYS-1:0] hits = i_touch & i_member;
    integer k, j;

    // lock owner: first touched member, lowest index on a tie
    always @* begin
        next_owner = owner;
        found = 1'b0;
        if ((owner & hits) == {KEYS{1'b0}}) begin
            next_owner = {KEYS{1'b0}};
            for (k = 0; k < KEYS; k = k + 1) begin
                if (hits[k] && !found) begin
                    next_owner[k] = 1'b1;
                    found = 1'b1;
                end
            end
        end
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            owner <= {KEYS{1'b0}};
        end else begin
            owner <= next_owner; // [R14]
        end
    end

    // strongest touched member, lowest index wins equal levels
    always @* begin
        best = {KEYS{1'b0}};
        best_lvl = {LW{1'b0}};
        for (j = 0; j < KEYS; j = j + 1) begin
            if (hits[j] && (best == {KEYS{1'b0}} || i_level[j*LW +: LW] > best_lvl)) begin
                best = {KEYS{1'b0}};
                best[j] = 1'b1;
                best_lvl = i_level[j*LW +: LW];
            end
        end
    end

    // non-members are never held back by this group
    always @* begin
        if (i_policy) begin
            o_allow = ~i_member | best; // [R15]
        end else begin
            o_allow = ~i_member | next_owner; // [R14]
        end
    end
endmodule

// [hdl/tks_top.v]
// parameter decoding, key state reporting, sleep control and bus wake detection
`include "tks_map.vh"
module tks_top #(
    parameter KEYS = 4,
    parameter GROUPS = 8,
    parameter LW = 8,
    parameter OUTS = 13,
    parameter TICK_CYC = `TKS_TICK_CYC,
    parameter [6:0] DEV_ADDR = 7'h2A // arbitrary default bus address
) (
    input wire i_clk,
    input wire i_resetn,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire [KEYS-1:0] i_key_detect,
    input wire [KEYS*LW-1:0] i_key_level,
    input wire [KEYS-1:0] i_key_cal,
    input wire [KEYS-1:0] i_key_err,
    input wire [KEYS-1:0] i_key_recal_filt,
    input wire [KEYS-1:0] i_key_di_filt,
    input wire [KEYS-1:0] i_key_edi_filt,
    input wire i_scl,
    input wire i_sda,
    output reg [KEYS-1:0] o_key_enable,
    output reg o_recal_start,
    output reg [OUTS-1:0] o_general_output,
    output reg o_asleep,
    output reg o_deep_sleep,
    output reg o_scan_wake,
    output reg o_bus_wake
);
    // reset release through two flops
    reg rst_meta, rstn;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rstn <= rst_meta;
        end
    end

    // parameter storage
    reg [15:0] opcode_hist;
    reg [7:0] sleep_config_byte, suppression_group_policy;
    reg [GROUPS*KEYS-1:0] memb_flat;
    reg [7:0] result_code, packed_touch_byte;
    reg [8*KEYS-1:0] dbg_flat;
    reg deep_req;

    wire [5:0] factor = sleep_config_byte[5:0];
    wire freerun = sleep_config_byte[`TKS_FREERUN_BIT];
    wire sleep_ok = (opcode_hist[7:0] == `TKS_OP_SLEEP);
    wire keyen_ok = (opcode_hist[7:0] == `TKS_OP_KEYEN);
    wire group_ok = (opcode_hist == `TKS_OP_GROUP);
    wire [3:0] key_id = i_wdata[3:0];
    wire key_id_ok = (key_id <= `TKS_KEYID_MAX);
    wire wr_memb = (i_addr >= `TKS_REG_MEMB0) && (i_addr <= `TKS_REG_MEMB3);
    wire [1:0] memb_idx = i_addr[1:0]; // membership block sits on a four-aligned offset

    // new key enable mask from a request byte
    reg [KEYS-1:0] next_enable;
    integer n;
    always @* begin
        next_enable = o_key_enable;
        for (n = 0; n < KEYS; n = n + 1) begin
            if (key_id == `TKS_KEYID_ALL || key_id == n[3:0] + 4'h1) begin // [R3]
                next_enable[n] = ~i_wdata[`TKS_EN_STATE_BIT]; // [R2]
            end
        end
    end

    // register writes; sleep, enable, policy and membership bytes count only after their opcode, output levels need none
    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            opcode_hist <= 16'h0000;
            sleep_config_byte <= 8'h00;
            suppression_group_policy <= 8'h00;
            memb_flat <= {GROUPS*KEYS{1'b0}};
            result_code <= `TKS_RES_OK;
            o_key_enable <= {KEYS{1'b1}};
            o_recal_start <= 1'b0;
            o_general_output <= {OUTS{1'b0}};
            deep_req <= 1'b0;
        end else begin
            o_recal_start <= 1'b0;
            deep_req <= 1'b0;
            if (i_wr) begin
                case (i_addr)
                    `TKS_REG_OPCODE: opcode_hist <= {opcode_hist[7:0], i_wdata};
                    `TKS_REG_SLEEP: begin
                        if (sleep_ok) begin // [R20]
                            sleep_config_byte <= {1'b0, i_wdata[6:0]}; // [R23]
                            deep_req <= (i_wdata[5:0] == `TKS_FAC_DEEP); // [R8]
                            result_code <= `TKS_RES_OK;
                        end else begin
                            result_code <= `TKS_RES_BADCMD;
                        end
                    end
                    `TKS_REG_KEYEN: begin
                        if (!keyen_ok) begin // [R21]
                            result_code <= `TKS_RES_BADCMD;
                        end else if (!key_id_ok) begin
                            result_code <= `TKS_RES_BADPAR;
                        end else begin
                            o_key_enable <= next_enable;
                            o_recal_start <= 1'b1; // [R19]
                            result_code <= `TKS_RES_OK;
                        end
                    end
                    `TKS_REG_POLICY: begin
                        if (group_ok) begin // [R22]
                            suppression_group_policy <= i_wdata;
                            result_code <= `TKS_RES_OK;
                        end else begin
                            result_code <= `TKS_RES_BADCMD;
                        end
                    end
                    `TKS_REG_OUT1: o_general_output[7:0] <= i_wdata; // [R13]
                    `TKS_REG_OUT2: o_general_output[OUTS-1:8] <= i_wdata[OUTS-9:0]; // [R13] [R23]
                    default: begin
                        if (wr_memb) begin
                            if (group_ok) begin // [R22]
                                memb_flat[memb_idx*GROUPS +: GROUPS] <= i_wdata; // [R16]
                                result_code <= `TKS_RES_OK;
                            end else begin
                                result_code <= `TKS_RES_BADCMD;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // per-group suppression; membership regrouped by group
    wire [GROUPS*KEYS-1:0] allow_flat;
    genvar g, q;
    generate
        for (g = 0; g < GROUPS; g = g + 1) begin : grp
            wire [KEYS-1:0] member;
            for (q = 0; q < KEYS; q = q + 1) begin : mb
                assign member[q] = memb_flat[q*GROUPS + g]; // [R16]
            end
            tks_group #(.KEYS(KEYS), .LW(LW)) u_grp (
                .i_clk(i_clk),
                .i_rstn(rstn),
                .i_member(member),
                .i_policy(suppression_group_policy[g]),
                .i_touch(i_key_detect & o_key_enable),
                .i_level(i_key_level),
                .o_allow(allow_flat[g*KEYS +: KEYS])
            );
        end
    endgenerate

    // a key reports only if every group it sits in lets it through
    reg [KEYS-1:0] allow_all;
    integer a;
    always @* begin
        allow_all = {KEYS{1'b1}};
        for (a = 0; a < GROUPS; a = a + 1) begin
            allow_all = allow_all & allow_flat[a*KEYS +: KEYS];
        end
    end

    // debug code per key, faults and calibration first
    reg [8*KEYS-1:0] next_dbg;
    integer d;
    always @* begin
        next_dbg = {8*KEYS{1'b0}};
        for (d = 0; d < KEYS; d = d + 1) begin
            if (i_key_err[d]) begin
                next_dbg[d*8 +: 8] = `TKS_DBG_ERR; // [R17]
            end else if (i_key_cal[d]) begin
                next_dbg[d*8 +: 8] = `TKS_DBG_CAL; // [R17]
            end else if (i_key_recal_filt[d]) begin
                next_dbg[d*8 +: 8] = `TKS_DBG_RECAL; // [R17]
            end else if (i_key_di_filt[d]) begin
                next_dbg[d*8 +: 8] = `TKS_DBG_DI; // [R18]
            end else if (i_key_edi_filt[d]) begin
                next_dbg[d*8 +: 8] = `TKS_DBG_EDI; // [R18]
            end else if (i_key_detect[d]) begin
                next_dbg[d*8 +: 8] = `TKS_DBG_TOUCH; // [R17]
            end else begin
                next_dbg[d*8 +: 8] = `TKS_DBG_REL; // [R17]
            end
        end
    end

    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            packed_touch_byte <= 8'h00;
            dbg_flat <= {8*KEYS{1'b0}};
        end else begin
            packed_touch_byte <= {{(8-KEYS){1'b0}}, i_key_detect & o_key_enable & allow_all}; // [R1]
            dbg_flat <= next_dbg;
        end
    end

    // read port: data stand the cycle after the strobe, zero otherwise
    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `TKS_REG_OPCODE: o_rdata <= opcode_hist[7:0];
                `TKS_REG_SLEEP: o_rdata <= sleep_config_byte;
                `TKS_REG_KEYEN: o_rdata <= {{(8-KEYS){1'b0}}, o_key_enable};
                `TKS_REG_POLICY: o_rdata <= suppression_group_policy;
                `TKS_REG_OUT1: o_rdata <= o_general_output[7:0];
                `TKS_REG_OUT2: o_rdata <= {{(16-OUTS){1'b0}}, o_general_output[OUTS-1:8]}; // [R23]
                `TKS_REG_TOUCH: o_rdata <= packed_touch_byte; // [R1]
                `TKS_REG_RESULT: o_rdata <= result_code;
                default: begin
                    if (wr_memb) begin
                        o_rdata <= memb_flat[memb_idx*GROUPS +: GROUPS];
                    end else if (i_addr >= `TKS_REG_DBG0) begin
                        o_rdata <= dbg_flat[(i_addr[1:0] - 2'd0)*8 +: 8];
                    end else begin
                        o_rdata <= 8'h00;
                    end
                end
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // bus pins: two flops, then one more for edge finding
    reg [1:0] scl_s, sda_s;
    reg scl_d, sda_d;
    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            scl_s <= 2'b11;
            sda_s <= 2'b11;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], i_scl};
            sda_s <= {sda_s[0], i_sda};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    wire scl_rise = scl_s[1] & ~scl_d;
    wire bus_act = (scl_s[1] ^ scl_d) | (sda_s[1] ^ sda_d);
    wire bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];

    // address snoop after a start; never drives the data line, so no acknowledge
    reg [3:0] bit_cnt;
    reg [7:0] addr_sh;
    reg addr_hit;
    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt <= 4'h0;
            addr_sh <= 8'h00;
            addr_hit <= 1'b0;
        end else begin
            addr_hit <= 1'b0;
            if (bus_start) begin
                bit_cnt <= 4'h8;
            end else if (scl_rise && bit_cnt != 4'h0) begin
                addr_sh <= {addr_sh[6:0], sda_s[1]};
                bit_cnt <= bit_cnt - 4'h1;
                if (bit_cnt == 4'h1) begin
                    addr_hit <= (addr_sh[6:0] == DEV_ADDR); // [R11]
                end
            end
        end
    end

    // 20 ms tick enable
    reg [31:0] tick_cnt;
    wire tick = (tick_cnt == TICK_CYC - 1);
    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= 32'h0;
        end else if (tick) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1; // [R24]
        end
    end

    // low power wanted: factor in range, not paused by a detecting key
    wire lp_factor = (factor != `TKS_FAC_OFF) && (factor <= `TKS_FAC_MAX_LP); // [R6] [R7]
    wire lp_pause = freerun && (i_key_detect != {KEYS{1'b0}}); // [R4] [R5]
    wire lp_want = lp_factor && !lp_pause;

    // power state machine
    localparam [1:0] PS_RUN = 2'h0, PS_SLEEP = 2'h1, PS_DEEP = 2'h2; // binary state codes
    reg [1:0] pstate;
    reg [5:0] slp_cnt;
    always @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            pstate <= PS_RUN;
            slp_cnt <= 6'h00;
            o_asleep <= 1'b0;
            o_deep_sleep <= 1'b0;
            o_scan_wake <= 1'b0;
            o_bus_wake <= 1'b0;
        end else begin
            o_scan_wake <= 1'b0;
            o_bus_wake <= 1'b0;
            case (pstate)
                PS_RUN: begin
                    if (deep_req) begin
                        pstate <= PS_DEEP; // [R8]
                        o_deep_sleep <= 1'b1;
                        o_asleep <= 1'b1;
                    end else if (lp_want && tick) begin
                        pstate <= PS_SLEEP;
                        slp_cnt <= 6'h00;
                        o_asleep <= 1'b1;
                    end
                end
                PS_SLEEP: begin
                    if (deep_req) begin
                        pstate <= PS_DEEP;
                        o_deep_sleep <= 1'b1;
                    end else if (bus_act || !lp_want) begin
                        pstate <= PS_RUN; // [R10] [R5] [R6]
                        o_asleep <= 1'b0;
                        o_bus_wake <= bus_act;
                    end else if (tick) begin
                        if (slp_cnt + 6'h01 >= factor) begin
                            slp_cnt <= 6'h00;
                            o_scan_wake <= 1'b1; // [R7]
                        end else begin
                            slp_cnt <= slp_cnt + 6'h01;
                        end
                    end
                end
                PS_DEEP: begin
                    if (addr_hit) begin
                        pstate <= PS_RUN; // [R9] [R11]
                        o_deep_sleep <= 1'b0;
                        o_asleep <= 1'b0;
                        o_bus_wake <= 1'b1;
                    end
                end
                default: begin
                    pstate <= PS_RUN;
                    o_asleep <= 1'b0;
                    o_deep_sleep <= 1'b0;
                end
            endcase
        end
    end
endmodule

// [bench/tks_chk.sv]
// concurrent checks on the touch key parameter block ports
module tks_chk #(
    parameter KEYS = 4,
    parameter OUTS = 13
) (
    input wire i_clk,
    input wire i_resetn,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire [KEYS-1:0] i_key_detect,
    input wire i_scl,
    input wire [KEYS-1:0] o_key_enable,
    input wire o_recal_start,
    input wire [OUTS-1:0] o_general_output,
    input wire o_asleep,
    input wire o_deep_sleep,
    input wire o_bus_wake
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // touch byte: reserved nibble and no key reported without its detect
    a_touch_upper: assert property (i_rd && i_addr == 4'hA |=> o_rdata[7:4] == 4'h0)
        else $error("touch byte upper bits set");
    a_touch_sub: assert property (i_rd && i_addr == 4'hA |=> (o_rdata[3:0] & ~$past(i_key_detect, 2)) == 4'h0)
        else $error("touch reported without detect");
    // a recalibration only ever follows a key enable write
    a_recal_src: assert property ($rose(o_recal_start) |-> $past(i_wr) && $past(i_addr) == 4'h2)
        else $error("recalibration without enable write");
    a_key_all: assert property (i_wr && i_addr == 4'h2 && i_wdata[3:0] == 4'h0 && $past(i_wr) && $past(i_addr) == 4'h0
        && $past(i_wdata) == 8'h97 |=> o_key_enable == {KEYS{~$past(i_wdata[7])}})
        else $error("all keys request not applied");
    a_gpo_low: assert property (i_wr && i_addr == 4'h8 |=> o_general_output[7:0] == $past(i_wdata))
        else $error("output byte one not applied");
    a_gpo_high: assert property (i_wr && i_addr == 4'h9 |=> o_general_output[12:8] == $past(i_wdata[4:0]))
        else $error("output byte two not applied");
    a_deep_enter: assert property (i_wr && i_addr == 4'h1 && i_wdata[5:0] == 6'h3F && $past(i_wr) && $past(i_addr) == 4'h0
        && $past(i_wdata) == 8'h92 |-> ##[1:3] o_deep_sleep)
        else $error("deep sleep not entered");
    a_deep_exit: assert property ($fell(o_deep_sleep) |-> o_bus_wake || $past(o_bus_wake))
        else $error("deep sleep left without address wake");
    // sync plus edge detect is a few cycles, so allow some slack
    a_sleep_wake: assert property (o_asleep && !o_deep_sleep && i_scl != $past(i_scl) |-> ##[1:8] o_bus_wake)
        else $error("bus activity did not wake");
endmodule

bind tks_top tks_chk #(.KEYS(KEYS), .OUTS(OUTS)) u_chk (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_key_detect, .i_scl, .o_key_enable, .o_recal_start, .o_general_output, .o_asleep, .o_deep_sleep, .o_bus_wake);

// [bench/tks_host.sv]
// bus master model: frames on the two-wire link, clock still between frames
module tks_host (
    output logic o_scl = 1'b1,
    output logic o_sda = 1'b1
);
    timeunit 1ns;
    timeprecision 100ps;
    // start, address and write bit msb first, ninth bit left to the pull-up, stop
    task automatic frame(input logic [6:0] a);
        logic [8:0] b;
        b = {a, 1'b0, 1'b1};
        o_sda = 1'b0;
        #80;
        for (int i = 8; i >= 0; i--) begin
            o_scl = 1'b0;
            #40 o_sda = b[i];
            #40 o_scl = 1'b1;
            #80;
        end
        o_scl = 1'b0;
        #40 o_sda = 1'b0;
        #40 o_scl = 1'b1;
        #40 o_sda = 1'b1;
        #80;
    endtask
    // the address is never acknowledged while waking, so always send twice
    task automatic send(input logic [6:0] a);
        frame(a);
        frame(a);
    endtask
endmodule

// [bench/tb_tks_top.sv]
// self-checking bench for the touch key parameter block
module tb_tks_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TK = 20; // shortened tick keeps sleep runs short
    localparam logic [7:0] DBG [7] = '{8'h08, 8'h01, 8'h11, 8'h14, 8'h24, 8'h04, 8'h02};
    localparam logic [7:0] OFF [3] = '{8'h80, 8'h20, 8'h3E};
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [3:0] i_key_detect = 4'h0;
    logic [31:0] i_key_level = 32'h0;
    logic [3:0] i_key_cal = 4'h0, i_key_err = 4'h0, i_key_recal_filt = 4'h0, i_key_di_filt = 4'h0, i_key_edi_filt = 4'h0;
    wire [7:0] o_rdata;
    wire [3:0] o_key_enable;
    wire [12:0] o_general_output;
    wire o_recal_start, o_asleep, o_deep_sleep, o_scan_wake, o_bus_wake, scl, sda;
    int n_mismatch = 0;
    int n_tests = 0, cnt;
    logic [3:0] en;
    logic [7:0] ga, gb;
    always #2.5 i_clk = ~i_clk;
    tks_host host (.o_scl(scl), .o_sda(sda));
    tks_top #(.TICK_CYC(TK)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_key_detect(i_key_detect), .i_key_level(i_key_level), .i_key_cal(i_key_cal),
        .i_key_err(i_key_err), .i_key_recal_filt(i_key_recal_filt), .i_key_di_filt(i_key_di_filt),
        .i_key_edi_filt(i_key_edi_filt), .i_scl(scl), .i_sda(sda), .o_key_enable(o_key_enable),
        .o_recal_start(o_recal_start), .o_general_output(o_general_output), .o_asleep(o_asleep),
        .o_deep_sleep(o_deep_sleep), .o_scan_wake(o_scan_wake), .o_bus_wake(o_bus_wake));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // strobe stays up so back-to-back calls never touch it twice per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        @(posedge i_clk);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), o_rdata, e);
    endtask
    task automatic idle(input int n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // bounded wait for a wake pulse, cycles taken left in cnt
    task automatic wait_hi(input bit bus, input int lim);
        cnt = 0;
        while ((bus ? o_bus_wake : o_scan_wake) !== 1'b1 && cnt < lim) begin
            @(posedge i_clk);
            #1 cnt++;
        end
        chk("wake pulse", cnt < lim, 1'b1);
    endtask
    function automatic logic [7:0] exp_touch(input logic [3:0] det, input logic [3:0] ena);
        return {4'h0, det & ena};
    endfunction
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #400us;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        void'($urandom(27));
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        idle(3);
        rc(4'hB, 8'h01);
        // key enable requests, all then one at a time
        wr(4'h0, 8'h97);
        wr(4'h2, 8'h80);
        wr(4'h2, 8'h00);
        #1 chk("enable", o_key_enable, 4'hF);
        en = 4'hF;
        for (int k = 1; k <= 4; k++) begin
            wr(4'h2, 8'h80 | k[7:0]);
            #1 chk("recal", o_recal_start, 1'b1);
            en[k-1] = 1'b0;
            chk("enable", o_key_enable, en);
        end
        wr(4'h2, 8'h03);
        en[2] = 1'b1;
        wr(4'h2, 8'h85);
        rc(4'h2, {4'h0, en});
        rc(4'hB, 8'h85);
        wr(4'h0, 8'h55);
        wr(4'h2, 8'h00);
        rc(4'hB, 8'h83);
        wr(4'h0, 8'h97);
        wr(4'h2, 8'h00);
        // output levels from random bytes
        repeat (4) begin
            ga = $urandom;
            gb = $urandom;
            wr(4'h8, ga);
            wr(4'h9, gb);
            #1 chk("outputs", o_general_output, {gb[4:0], ga});
            rc(4'h9, gb & 8'h1F);
        end
        // debug code for each status of key one
        for (int k = 0; k < 7; k++) begin
            {i_key_edi_filt[0], i_key_di_filt[0], i_key_recal_filt[0], i_key_cal[0], i_key_err[0]} <= 5'h01 << k;
            i_key_detect <= {3'h0, k == 5};
            idle(2);
            rc(4'hC, DBG[k]);
        end
        // touch byte with no groups, random detect and levels
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h09);
        for (int k = 3; k < 8; k++)
            wr(k[3:0], 8'h00);
        repeat (8) begin
            i_key_detect <= $urandom;
            i_key_level <= $urandom;
            idle(2);
            rc(4'hA, exp_touch(i_key_detect, 4'hF));
        end
        // key1 in groups 1 and 8, key2 in 8, key4 in 1, key3 free
        wr(4'h3, 8'hFF);
        wr(4'h4, 8'h81);
        wr(4'h5, 8'h80);
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h01);
        i_key_level <= 32'h30902010;
        i_key_detect <= 4'hF;
        idle(3);
        rc(4'hA, 8'h0E);
        wr(4'h3, 8'h00);
        i_key_detect <= 4'h1;
        idle(3);
        i_key_detect <= 4'hF;
        idle(3);
        rc(4'hA, 8'h05);
        // sleep interval with keys detecting and free run off
        wr(4'h0, 8'h92);
        wr(4'h1, 8'h02);
        idle(1);
        wait_hi(0, 4 * TK);
        idle(1);
        wait_hi(0, 4 * TK);
        chk("interval", cnt + 1, 2 * TK);
        chk("asleep", o_asleep, 1'b1);
        wr(4'h1, 8'h42);
        idle(3 * TK);
        chk("asleep", o_asleep, 1'b0);
        i_key_detect <= 4'h0;
        idle(3 * TK);
        chk("asleep", o_asleep, 1'b1);
        fork
            host.send(7'h11);
            wait_hi(1, 200);
        join
        foreach (OFF[i]) begin
            wr(4'h1, OFF[i]);
            idle(3 * TK);
            chk("asleep", o_asleep, 1'b0);
        end
        // deep sleep ignores foreign frames, leaves on its own address
        wr(4'h0, 8'h92);
        wr(4'h1, 8'h3F);
        idle(2);
        chk("deep", o_deep_sleep, 1'b1);
        host.send(7'h11);
        chk("deep", o_deep_sleep, 1'b1);
        fork
            host.send(7'h2A);
            wait_hi(1, 600);
        join
        chk("deep", o_deep_sleep, 1'b0);
        give_verdict();
    end
endmodule
